// *** src/map_pkg.sv ***
// Purpose: Constants for the address decoder and I/O access bridge.
// Assumes: One 32-bit flat address space, one core clock.
// Notes: Peripheral window layout and clock divide are fixed here.
package map_pkg;
	// Capacity strap codes.
	localparam logic [2:0] ROM_512K = 3'h0;
	localparam logic [2:0] ROM_384K = 3'h1;
	localparam logic [2:0] ROM_256K = 3'h2;
	localparam logic [2:0] ROM_128K = 3'h3;
	localparam logic [1:0] RAM_48K = 2'h0;
	localparam logic [1:0] RAM_32K = 2'h1;
	localparam logic [1:0] RAM_16K = 2'h2;
	// ROM start addresses; ROM always ends at the top address.
	localparam logic [31:0] ROM_START_512K = 32'hFFF8_0000;
	localparam logic [31:0] ROM_START_384K = 32'hFFFA_8000;
	localparam logic [31:0] ROM_START_256K = 32'hFFFC_0000;
	localparam logic [31:0] ROM_START_128K = 32'hFFFE_0000;
	localparam logic [31:0] ROM_START_64K = 32'hFFFF_0000;
	// RAM end addresses; RAM always starts at zero.
	localparam logic [31:0] RAM_END_48K = 32'h0000_BFFF;
	localparam logic [31:0] RAM_END_32K = 32'h0000_7FFF;
	localparam logic [31:0] RAM_END_16K = 32'h0000_3FFF;
	localparam logic [31:0] RAM_END_10K = 32'h0000_27FF;
	// I/O region, selected by address bits 31:20, and peripheral bus windows, selected by address bits 19:16.
	localparam logic [11:0] IO_PAGE = 12'h000;
	localparam logic [3:0] PB1_SEL = 4'h8;
	localparam logic [3:0] PB2_SEL = 4'h9;
	localparam logic [3:0] PB3_SEL = 4'hA;
	localparam logic [3:0] PB6_SEL = 4'hC;
	localparam logic [1:0] PB1_CODE = 2'h0;
	localparam logic [1:0] PB2_CODE = 2'h1;
	localparam logic [1:0] PB3_CODE = 2'h2;
	localparam logic [1:0] PB6_CODE = 2'h3;
	// Bus-error registers sit in the first 256 bytes of peripheral bus 2.
	localparam logic [23:0] BUSERR_PAGE = 24'h0009_00;
	// Peripheral clock period in core clock cycles.
	localparam logic [7:0] PCLK_DIV = 8'h04;
	localparam logic [7:0] CYC_RESET = 8'h00;
	localparam logic [7:0] CYC_FIRST = 8'h01;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
endpackage

// *** src/memory_map_and_io_access.sv ***
// Purpose: Address decode of the flat space and posted, ordered I/O register access.
// Assumes: Master, memories and peripheral buses run on clk_in; startup pin is asynchronous.
// Notes: One I/O access in flight at a time, which is what keeps writes in order.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Decode full 32-bit linear 4-Gbyte space.
// - ROM ends at top, start by capacity.
// - RAM starts at zero, end by capacity.
// - Same decode in boot and single-chip.
// - I/O writes are posted, acknowledged early.
// - Writes complete in order; last read-back suffices.
// - I/O cycles: main plus sync plus peripheral.
// - Peripheral cycles depend on addressed register.
// - Sync only on buses 2,3,6, not bus-error.
// - Main plus sync within one peripheral period.
// - Next access starts cycle after completion.
// - Counts hold only without fetch or master conflict.
module memory_map_and_io_access (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic startup_mode_pin_in,
	input wire logic [2:0] rom_cap_sel_in,
	input wire logic [1:0] ram_cap_sel_in,
	input wire logic conflict_in,
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic [31:0] req_addr_in,
	input wire logic req_we_in,
	input wire logic [31:0] req_wdata_in,
	output logic resp_valid_out,
	output logic [31:0] resp_rdata_out,
	output logic resp_err_out,
	output logic mem_ram_sel_out,
	output logic mem_rom_sel_out,
	output logic [31:0] mem_addr_out,
	output logic mem_we_out,
	output logic [31:0] mem_wdata_out,
	input wire logic [31:0] mem_rdata_in,
	output logic per_req_out,
	output logic [1:0] per_bus_out,
	output logic [31:0] per_addr_out,
	output logic per_we_out,
	output logic [31:0] per_wdata_out,
	input wire logic [31:0] per_rdata_in,
	input wire logic per_ready_in,
	output logic io_done_out,
	output logic [7:0] io_cycles_out,
	output logic unmapped_out,
	output logic boot_mode_out
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MAIN = 2'b01,
		ST_SYNC = 2'b10,
		ST_PERI = 2'b11
	} state_e;

	state_e state_q, state_d;
	logic md_s1_q, md_s2_q;
	logic [7:0] pdiv_q, cyc_q;
	logic [31:0] addr_q, wdata_q, rdata_q;
	logic we_q, sync_q, resp_q, err_q, done_q, unmapped_q;
	logic [1:0] bus_q;
	logic [7:0] io_cyc_q;

	////////////////////////////////////////////////////////////////////////////////
	// Decode. The startup pin is only reported; it never reaches the decode.
	wire [31:0] rom_start = (rom_cap_sel_in == map_pkg::ROM_512K) ? map_pkg::ROM_START_512K :
		(rom_cap_sel_in == map_pkg::ROM_384K) ? map_pkg::ROM_START_384K :
		(rom_cap_sel_in == map_pkg::ROM_256K) ? map_pkg::ROM_START_256K :
		(rom_cap_sel_in == map_pkg::ROM_128K) ? map_pkg::ROM_START_128K : map_pkg::ROM_START_64K;
	wire [31:0] ram_end = (ram_cap_sel_in == map_pkg::RAM_48K) ? map_pkg::RAM_END_48K :
		(ram_cap_sel_in == map_pkg::RAM_32K) ? map_pkg::RAM_END_32K :
		(ram_cap_sel_in == map_pkg::RAM_16K) ? map_pkg::RAM_END_16K : map_pkg::RAM_END_10K;
	wire hit_rom = req_addr_in >= rom_start;
	wire hit_ram = req_addr_in <= ram_end;
	wire [3:0] io_win = req_addr_in[19:16];
	wire in_io_page = req_addr_in[31:20] == map_pkg::IO_PAGE;
	wire hit_pb1 = in_io_page && io_win == map_pkg::PB1_SEL;
	wire hit_pb2 = in_io_page && io_win == map_pkg::PB2_SEL;
	wire hit_pb3 = in_io_page && io_win == map_pkg::PB3_SEL;
	wire hit_pb6 = in_io_page && io_win == map_pkg::PB6_SEL;
	wire hit_io = hit_pb1 | hit_pb2 | hit_pb3 | hit_pb6;
	wire hit_none = !(hit_rom | hit_ram | hit_io);
	wire [1:0] bus_code = hit_pb2 ? map_pkg::PB2_CODE : hit_pb3 ? map_pkg::PB3_CODE :
		hit_pb6 ? map_pkg::PB6_CODE : map_pkg::PB1_CODE;
	wire is_buserr = req_addr_in[31:8] == map_pkg::BUSERR_PAGE;
	wire need_sync = (hit_pb2 | hit_pb3 | hit_pb6) && !is_buserr;

	// A conflicting fetch or other master holds new requests off, so counts stay exact.
	assign req_ready_out = (state_q == ST_IDLE) && !conflict_in;
	wire take = req_valid_in && req_ready_out;
	wire take_mem = take && (hit_rom || hit_ram);
	wire take_io = take && hit_io;
	wire take_none = take && hit_none;
	wire tick = pdiv_q == (map_pkg::PCLK_DIV - 8'h01);
	wire peri_end = (state_q == ST_PERI) && per_ready_in;

	assign mem_ram_sel_out = take && hit_ram;
	assign mem_rom_sel_out = take && hit_rom;
	assign mem_addr_out = req_addr_in;
	assign mem_we_out = take && hit_ram && req_we_in;
	assign mem_wdata_out = req_wdata_in;
	assign per_req_out = state_q == ST_PERI;
	assign per_bus_out = bus_q;
	assign per_addr_out = addr_q;
	assign per_we_out = we_q;
	assign per_wdata_out = wdata_q;
	assign resp_valid_out = resp_q;
	assign resp_rdata_out = rdata_q;
	assign resp_err_out = err_q;
	assign io_done_out = done_q;
	assign io_cycles_out = io_cyc_q;
	assign unmapped_out = unmapped_q;
	assign boot_mode_out = !md_s2_q;

	////////////////////////////////////////////////////////////////////////////////
	// Access sequencer. Sync waits for the peripheral clock edge, so main plus sync
	// never exceeds one peripheral period.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (take_io) begin
					state_d = ST_MAIN;
				end
			end
			ST_MAIN: begin
				// Skipping sync on a divider tick keeps main plus sync within four cycles.
				state_d = (sync_q && !tick) ? ST_SYNC : ST_PERI;
			end
			ST_SYNC: begin
				if (tick) begin
					state_d = ST_PERI;
				end
			end
			ST_PERI: begin
				if (per_ready_in) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q <= ST_IDLE;
			md_s1_q <= 1'b1;
			md_s2_q <= 1'b1;
			pdiv_q <= map_pkg::CYC_RESET;
		end else begin
			state_q <= state_d;
			md_s1_q <= startup_mode_pin_in;
			md_s2_q <= md_s1_q;
			pdiv_q <= tick ? map_pkg::CYC_RESET : pdiv_q + 8'h01;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			addr_q <= map_pkg::WORD_RESET;
			wdata_q <= map_pkg::WORD_RESET;
			we_q <= 1'b0;
			sync_q <= 1'b0;
			bus_q <= map_pkg::PB1_CODE;
			cyc_q <= map_pkg::CYC_RESET;
		end else begin
			if (take_io) begin
				addr_q <= req_addr_in;
				wdata_q <= req_wdata_in;
				we_q <= req_we_in;
				sync_q <= need_sync;
				bus_q <= bus_code;
				cyc_q <= map_pkg::CYC_FIRST;
			end else if (state_q != ST_IDLE) begin
				cyc_q <= cyc_q + 8'h01;
			end
		end
	end

	// Write answers go out at the take, ahead of completion; I/O read answers wait for the peripheral bus.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			resp_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= map_pkg::WORD_RESET;
			done_q <= 1'b0;
			unmapped_q <= 1'b0;
			io_cyc_q <= map_pkg::CYC_RESET;
		end else begin
			resp_q <= take_mem || take_none || (take_io && req_we_in) || (peri_end && !we_q);
			err_q <= take_none;
			unmapped_q <= take_none;
			done_q <= peri_end;
			if (take_mem) begin
				rdata_q <= mem_rdata_in;
			end else if (take_none) begin
				rdata_q <= map_pkg::WORD_RESET;
			end else if (peri_end && !we_q) begin
				rdata_q <= per_rdata_in;
			end
			if (peri_end) begin
				io_cyc_q <= cyc_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	logic [7:0] chk_sync_q, chk_peri_q;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			chk_sync_q <= map_pkg::CYC_RESET;
			chk_peri_q <= map_pkg::CYC_RESET;
		end else begin
			chk_sync_q <= take_io ? map_pkg::CYC_RESET : chk_sync_q + {7'h00, state_q == ST_SYNC};
			chk_peri_q <= take_io ? map_pkg::CYC_RESET : chk_peri_q + {7'h00, state_q == ST_PERI};
		end
	end

	sequence s_io_write_taken;
		take_io && req_we_in;
	endsequence
	sequence s_main_to_peri;
		(state_q == ST_MAIN && sync_q) ##[1:4] (state_q == ST_PERI);
	endsequence

	a_posted_write_ack: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_io_write_taken |=> resp_valid_out && !io_done_out && state_q == ST_MAIN) else $error("posted write not acknowledged early");
	a_single_inflight: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_q != ST_IDLE) |-> !req_ready_out) else $error("new request taken while I/O busy");
	a_unmapped_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
		take_none |-> !mem_we_out ##1 (resp_err_out && unmapped_out && state_q == ST_IDLE)) else $error("unmapped access not flagged");
	a_sync_bounded: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_q == ST_MAIN && sync_q) |-> s_main_to_peri) else $error("sync exceeded one peripheral period");
	a_sync_count: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_q == ST_SYNC) |-> chk_sync_q < 8'h03) else $error("too many sync cycles");
	a_no_sync_skip: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(state_q == ST_MAIN && !sync_q) |=> state_q == ST_PERI) else $error("sync added on a bus without it");
	a_cycle_sum: assert property (@(posedge clk_in) disable iff (!rstn_in)
		io_done_out |-> io_cycles_out == 8'h01 + chk_sync_q + chk_peri_q) else $error("I/O cycle count wrong");
	a_next_access: assert property (@(posedge clk_in) disable iff (!rstn_in)
		peri_end |=> (req_ready_out || conflict_in)) else $error("next access not available after completion");
	a_read_data: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(peri_end && !we_q) |=> resp_valid_out && resp_rdata_out == $past(per_rdata_in)) else $error("peripheral read data lost");
	a_conflict_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
		conflict_in |-> !req_ready_out) else $error("request taken during conflict");
	a_ram_bottom: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(take && req_addr_in == 32'h0000_0000) |-> mem_ram_sel_out) else $error("address zero not in RAM");
	a_rom_top: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(take && req_addr_in == 32'hFFFF_FFFF) |-> mem_rom_sel_out) else $error("top address not in ROM");
endmodule

// *** test/memory_map_and_io_access_tb.sv ***
// Purpose: Self-checking bench for the address decoder and I/O access bridge.
// Assumes: The peripheral side is served by periph_model.
// Notes: Memory read data is the inverted address, so a wrong select shows at once.
`timescale 1ns/1ns
module memory_map_and_io_access_tb;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic startup_mode_pin_in = 1'b1;
	logic conflict_in = 1'b0;
	logic req_valid_in = 1'b0;
	logic req_we_in = 1'b0;
	logic [2:0] rom_cap_sel_in = 3'h0;
	logic [1:0] ram_cap_sel_in = 2'h0;
	logic [31:0] req_addr_in = 32'h0000_0000;
	logic [31:0] req_wdata_in = 32'h0000_0000;
	logic req_ready_out, resp_valid_out, resp_err_out, mem_ram_sel_out, mem_rom_sel_out, mem_we_out;
	logic per_req_out, per_we_out, per_ready_in, io_done_out, unmapped_out, boot_mode_out;
	logic [1:0] per_bus_out;
	logic [7:0] io_cycles_out;
	logic [31:0] resp_rdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in, per_addr_out, per_wdata_out, per_rdata_in;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	int lat, pre, hi;
	logic s_ram, s_rom, s_we, err, unm, dn, rdy;
	logic [31:0] rd, wd;
	logic [7:0] cyc;
	logic [31:0] rom_start [5] = '{32'hFFF8_0000, 32'hFFFA_8000, 32'hFFFC_0000, 32'hFFFE_0000, 32'hFFFF_0000};
	logic [31:0] ram_end [4] = '{32'h0000_BFFF, 32'h0000_7FFF, 32'h0000_3FFF, 32'h0000_27FF};
	logic [31:0] io_addr [5] = '{32'h0008_0010, 32'h0009_0008, 32'h0009_0104, 32'h000A_0008, 32'h000C_000C};
	////////////////////////////////////////////////////////////////////////////////
	memory_map_and_io_access dut_u (.clk_in, .rstn_in, .startup_mode_pin_in, .rom_cap_sel_in, .ram_cap_sel_in,
		.conflict_in, .req_valid_in, .req_ready_out, .req_addr_in, .req_we_in, .req_wdata_in, .resp_valid_out,
		.resp_rdata_out, .resp_err_out, .mem_ram_sel_out, .mem_rom_sel_out, .mem_addr_out, .mem_we_out,
		.mem_wdata_out, .mem_rdata_in, .per_req_out, .per_bus_out, .per_addr_out, .per_we_out, .per_wdata_out,
		.per_rdata_in, .per_ready_in, .io_done_out, .io_cycles_out, .unmapped_out, .boot_mode_out);
	periph_model pm_u (.clk_in, .rstn_in, .per_req_in(per_req_out), .per_bus_in(per_bus_out),
		.per_addr_in(per_addr_out), .per_we_in(per_we_out), .per_wdata_in(per_wdata_out),
		.per_rdata_out(per_rdata_in), .per_ready_out(per_ready_in));
	assign mem_rdata_in = ~mem_addr_out;
	always #2 clk_in = ~clk_in;
	// The whole run needs well under a thousand cycles; the ceiling leaves wide margin.
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task acc(input logic [31:0] a, input logic w, input logic [31:0] d, input logic io);
		@(posedge clk_in);
		#1;
		req_addr_in = a;
		req_we_in = w;
		req_wdata_in = d;
		req_valid_in = 1'b1;
		#2;
		for (int i = 0; i < 60 && req_ready_out !== 1'b1; i++) begin
			@(posedge clk_in);
			#3;
		end
		s_ram = mem_ram_sel_out;
		s_rom = mem_rom_sel_out;
		s_we = mem_we_out;
		wd = mem_wdata_out;
		@(posedge clk_in);
		#1;
		req_valid_in = 1'b0;
		{lat, pre, hi, unm, dn} = {-32'sd1, 32'd0, 32'd0, 2'b00};
		for (int i = 0; i < 60; i++) begin
			#2;
			if (per_req_out === 1'b1) hi++;
			else if (hi == 0) pre++;
			if (unmapped_out === 1'b1) unm = 1'b1;
			if (resp_valid_out === 1'b1 && lat < 0) begin
				lat = i;
				rd = resp_rdata_out;
				err = resp_err_out;
			end
			if (io_done_out === 1'b1) begin
				dn = 1'b1;
				cyc = io_cycles_out;
				rdy = req_ready_out;
			end
			if (lat >= 0 && (!io || dn)) break;
			@(posedge clk_in);
			#1;
		end
		// Realign to the usual drive point so every input moves one step after an edge.
		@(posedge clk_in);
		#1;
	endtask
	task io(input logic [31:0] a, input logic w, input logic [31:0] d, input logic sync);
		acc(a, w, d, 1'b1);
		chk("io_done", dn, 1);
		chk("io_cycles", cyc, pre + hi);
		chk("per_cycles", hi, a[3:2] + 1);
		if (sync) chk("sync_span", pre >= 1 && pre <= 4, 1);
		else chk("main_only", pre, 1);
		chk("ready_back", rdy, 1);
		if (w) chk("posted", lat, 0);
		else chk("read_back", rd, d);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_decode(input logic pin);
		startup_mode_pin_in = pin;
		repeat (3) @(posedge clk_in);
		#1;
		chk("boot_mode", boot_mode_out, !pin);
		for (int k = 0; k < 5; k++) begin
			rom_cap_sel_in = 3'(k);
			acc(rom_start[k], 1'b0, 0, 1'b0);
			chk("rom_sel", s_rom, 1);
			acc(rom_start[k] - 4, 1'b0, 0, 1'b0);
			chk("below_rom", unm, 1);
		end
		for (int k = 0; k < 4; k++) begin
			ram_cap_sel_in = 2'(k);
			acc(ram_end[k] - 3, 1'b0, 0, 1'b0);
			chk("ram_sel", s_ram, 1);
			chk("ram_data", rd, ~(ram_end[k] - 3));
			acc(ram_end[k] + 1, 1'b0, 0, 1'b0);
			chk("above_ram", unm, 1);
		end
		acc(32'hFFFF_FFFF, 1'b1, 32'h1111_2222, 1'b0);
		chk("rom_top", s_rom, 1);
		chk("rom_no_write", s_we, 0);
		$display("decode test done, pin %b", pin);
	endtask
	task t_unmapped();
		acc(32'h000B_0000, 1'b1, 32'h1234_5678, 1'b0);
		chk("err", err, 1);
		chk("flag", unm, 1);
		chk("no_write", s_we, 0);
		acc(32'h1000_0000, 1'b0, 0, 1'b0);
		chk("mid_rdata", rd, 0);
		acc(32'h0000_0100, 1'b1, 32'h1234_5678, 1'b0);
		chk("ram_write", s_we, 1);
		chk("ram_wdata", wd, 32'h1234_5678);
		acc(32'h0000_0000, 1'b0, 0, 1'b0);
		chk("ram_zero", s_ram, 1);
		chk("zero_data", rd, 32'hFFFF_FFFF);
		$display("unmapped test done");
	endtask
	task t_order();
		for (int k = 0; k < 5; k++) io(io_addr[k], 1'b1, 32'hA5A5_0000 + k, k > 1);
		for (int k = 0; k < 5; k++) io(io_addr[k], 1'b0, 32'hA5A5_0000 + k, k > 1);
		$display("order test done");
	endtask
	task t_conflict();
		conflict_in = 1'b1;
		fork
			acc(32'h0000_0040, 1'b0, 0, 1'b0);
			begin
				repeat (4) @(posedge clk_in);
				#1;
				chk("held_off", req_ready_out, 0);
				conflict_in = 1'b0;
			end
		join
		chk("late_take", rd, ~32'h0000_0040);
		$display("conflict test done");
	endtask
	task finish_test();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_in);
		#1;
		rstn_in = 1'b1;
		t_decode(1'b1);
		t_decode(1'b0);
		t_unmapped();
		t_order();
		t_conflict();
		finish_test();
	end
endmodule

// *** test/periph_model.sv ***
// Purpose: Peripheral bus target that answers the bridge's I/O accesses.
// Assumes: A request is held until ready is sampled high.
// Notes: Wait states come from address bits 3:2, so a register's cycle count follows its word address modulo four.
`timescale 1ns/1ns
module periph_model (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic per_req_in,
	input wire logic [1:0] per_bus_in,
	input wire logic [31:0] per_addr_in,
	input wire logic per_we_in,
	input wire logic [31:0] per_wdata_in,
	output logic [31:0] per_rdata_out,
	output logic per_ready_out
);
	////////////////////////////////////////////////////////////////////////////////
	logic [31:0] regs_q [64];
	logic [31:0] last_q;
	logic [1:0] cnt_q;
	wire [5:0] idx = {per_bus_in, per_addr_in[5:2]};
	assign per_ready_out = per_req_in && (cnt_q == per_addr_in[3:2]);
	// An idle data bus shows the inverse of the last word, so stale data never passes as a match.
	assign per_rdata_out = per_ready_out ? regs_q[idx] : ~last_q;
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_q <= 2'h0;
			last_q <= 32'h0000_0000;
		end else begin
			cnt_q <= (per_req_in && !per_ready_out) ? cnt_q + 2'h1 : 2'h0;
			if (per_ready_out) begin
				last_q <= per_rdata_out;
				if (per_we_in) regs_q[idx] <= per_wdata_in;
			end
		end
	end
endmodule
